// file: core/vwcc_capture_link.sv
// Capture-clock side: reference edge detection, field tracking and pixel reduction
`default_nettype none
`include "vwcc_params.svh"
module vwcc_capture_link
   import vwcc_pkg::*;
(
   // Link clock and reset
   input wire logic cap_clk_i,
   input wire logic cap_rst_i,
   // Strobes from the source
   input wire logic vref_i,
   input wire logic capture_horizontal_ref_i,
   // Settings, held stable by software while capturing
   input wire logic capture_horizontal_ref_falling_i,
   input wire logic [2:0] hred_code_i,
   input wire logic hred_allowed_i,
   // Results
   output logic vref_fall_toggle_o,
   output logic field_odd_o,
   output logic pixel_keep_o
);
   typedef struct packed {
      logic vref_d;
      logic capture_horizontal_ref_d;
      logic fall_tgl;
      logic field_odd;
      logic [4:0] pix_cnt;
      logic keep;
   } vwcc_link_s;
   vwcc_link_s st_reg, st_next;
   logic [4:0] mask;
   always_comb begin
      st_next = st_reg;
      st_next.vref_d = vref_i;
      st_next.capture_horizontal_ref_d = capture_horizontal_ref_i;
      // Codes 110 and 111 are reserved; treat them as keep-all
      case (hred_code_i)
         3'h1: mask = 5'h01;
         3'h2: mask = 5'h03;
         3'h3: mask = 5'h07;
         3'h4: mask = 5'h0f;
         3'h5: mask = 5'h1f;
         default: mask = 5'h00;
      endcase
      if (st_reg.vref_d && !vref_i) begin
         st_next.fall_tgl = ~st_reg.fall_tgl;
         st_next.field_odd = ~st_reg.field_odd;
      end
      if ((capture_horizontal_ref_falling_i && st_reg.capture_horizontal_ref_d && !capture_horizontal_ref_i) || (!capture_horizontal_ref_falling_i && !st_reg.capture_horizontal_ref_d && capture_horizontal_ref_i)) begin
         st_next.pix_cnt = 5'h00;
      end else begin
         st_next.pix_cnt = st_reg.pix_cnt + 5'h01;
      end
      st_next.keep = !hred_allowed_i || ((st_next.pix_cnt & mask) == 5'h00);
   end
   always_ff @(posedge cap_clk_i) begin
      if (cap_rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign vref_fall_toggle_o = st_reg.fall_tgl;
   assign field_odd_o = st_reg.field_odd;
   assign pixel_keep_o = st_reg.keep;
endmodule
`default_nettype wire

// file: core/vwcc_top.sv
// Video window and capture control registers with stride, field and interrupt logic
`default_nettype none
`include "vwcc_params.svh"
// Notes on behaviour
// - 12-bit stride: extension, offset byte, three zeros
// - Interleaved capture doubles the capture stride
// - Forced offset gives fixed 1024-byte capture stride
// - Window bit 7 enables per-pixel overlay
// - Window bit 5 enables luma dither in packed display format
// - Bit 4 replicates lines, else interpolates
// - Display format decode; others reserved
// - Enable waits for vsync, disable immediate
// - Status mirrors reference and field identity
// - Misc bit 5 selects interrupt source
// - Interrupt on reference fall or vsync rise; zero clears
// - Auto-decimation drops high word, halves offset
// - Page bit replaces address bit 21
// - Current capture buffer latched at reference fall
// - Interlaced capture: odd offset, double stride
// - Clock invert, 16-bit port, double edge
// - Field select picks captured fields
// - Pin configuration selects line start edge
// - Capture enable sampled at reference fall
// - Capture format decode; compressed forbids horizontal reduction
// - Horizontal reduction keeps every 2^n pixel
module vwcc_top
   import vwcc_pkg::*;
(
   // System clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // Indexed register port
   input wire logic [7:0] REG_INDEX_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WRITE_I,
   output logic [7:0] REG_RDATA_O,
   // Capture link
   input wire logic CAP_PIXEL_CLOCK_I,
   input wire logic CAP_RST_I,
   input wire logic CAP_VERTICAL_REF_I,
   input wire logic CAPTURE_HORIZONTAL_REF_I,
   // Display pipeline
   input wire logic DISP_VSYNC_I,
   input wire logic APERTURE_WRITE_I,
   input wire logic [21:0] APERTURE_OFFSET_I,
   input wire logic [3:0] APERTURE_BE_I,
   output logic WINDOW_ACTIVE_O,
   output logic OVERLAY_EN_O,
   output logic DITHER_EN_O,
   output logic ZOOM_REPLICATE_O,
   output logic [2:0] DISPLAY_FORMAT_O,
   output logic DISPLAY_FORMAT_RESERVED_O,
   output logic [11:0] WINDOW_STRIDE_O,
   output logic [12:0] CAPTURE_STRIDE_O,
   output logic [12:0] CAPTURE_FIELD_START_O,
   output logic CAPTURE_ACTIVE_O,
   output logic CAPTURE_FIELD_TAKEN_O,
   output logic CAPTURE_CLOCK_INVERT_O,
   output logic CAPTURE_PORT16_O,
   output logic CAPTURE_DOUBLE_EDGE_O,
   output logic FEATURE_CONNECTOR_O,
   output logic PIXEL_KEEP_O,
   output logic DECIMATE_DROP_O,
   output logic [21:0] DECIMATE_ADDR_O,
   output logic INTERRUPT_REQUEST_PIN_N_O
);
   typedef struct packed {
      logic [7:0] addr_high;
      logic [7:0] stride;
      logic [7:0] win_ctrl;
      logic [7:0] misc;
      logic [7:0] cap_ctrl;
      logic [7:0] cap_fmt;
      logic [7:0] hred;
      logic [7:0] vred;
      logic [7:0] luma;
      vwcc_win_state_e win_state;
      logic [1:0] vref_sync;
      logic [1:0] fld_sync;
      logic [2:0] tgl_sync;
      logic [1:0] vs_sync;
      logic vs_d;
      logic cap_active;
      logic cur_buf;
      logic [1:0] field_cnt;
      logic field_taken;
      logic irq_pend;
      logic [7:0] rdata;
      logic drop;
      logic [21:0] daddr;
   } vwcc_state_s;
   vwcc_state_s st_reg, st_next;
   logic link_tgl, link_field, link_keep;
   logic vref_fall, vs_rise, src_edge, take;
   logic [11:0] stride12;
   logic [12:0] cap_stride;
   logic decim_on, rgb_disp, hred_ok;

   function automatic logic [7:0] read_index(input vwcc_state_s s, input logic [7:0] idx);
      logic [7:0] v;
      v = 8'h00;
      case (idx)
         `VWCC_IDX_WIN_ADDR_HIGH: v = s.addr_high;
         `VWCC_IDX_STRIDE: v = s.stride;
         `VWCC_IDX_WIN_CTRL: v = s.win_ctrl;
         `VWCC_IDX_MISC: begin
            v = s.misc;
            v[`VWCC_MISC_VREF] = s.vref_sync[1];
            v[`VWCC_MISC_FIELD] = s.fld_sync[1];
            v[`VWCC_MISC_CUR_BUF] = s.cur_buf;
         end
         `VWCC_IDX_CAP_CTRL: v = s.cap_ctrl;
         `VWCC_IDX_CAP_FMT: v = s.cap_fmt;
         `VWCC_IDX_CAP_HRED: v = s.hred;
         `VWCC_IDX_CAP_VRED: v = s.vred;
         `VWCC_IDX_LUMA_CTRL: v = s.luma;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // Line-start edge and reduction counting run on the source's own clock
   vwcc_capture_link u_link (
      .cap_clk_i(CAP_PIXEL_CLOCK_I),
      .cap_rst_i(CAP_RST_I),
      .vref_i(CAP_VERTICAL_REF_I),
      .capture_horizontal_ref_i(CAPTURE_HORIZONTAL_REF_I),
      .capture_horizontal_ref_falling_i(st_reg.cap_ctrl[0]),
      .hred_code_i(st_reg.hred[2:0]),
      .hred_allowed_i(hred_ok),
      .vref_fall_toggle_o(link_tgl),
      .field_odd_o(link_field),
      .pixel_keep_o(link_keep)
   );

   always_comb begin
      st_next = st_reg;
      // Two flops before use; the toggle and vsync edge detects compare the second stage with a third
      st_next.vref_sync = {st_reg.vref_sync[0], CAP_VERTICAL_REF_I};
      st_next.fld_sync = {st_reg.fld_sync[0], link_field};
      st_next.tgl_sync = {st_reg.tgl_sync[1:0], link_tgl};
      st_next.vs_sync = {st_reg.vs_sync[0], DISP_VSYNC_I};
      st_next.vs_d = st_reg.vs_sync[1];
      vref_fall = st_reg.tgl_sync[2] ^ st_reg.tgl_sync[1];
      vs_rise = st_reg.vs_sync[1] && !st_reg.vs_d;
      if (REG_WRITE_I) begin
         case (REG_INDEX_I)
            `VWCC_IDX_WIN_ADDR_HIGH: st_next.addr_high = REG_WDATA_I;
            `VWCC_IDX_STRIDE: st_next.stride = REG_WDATA_I;
            `VWCC_IDX_WIN_CTRL: st_next.win_ctrl = REG_WDATA_I;
            `VWCC_IDX_MISC: st_next.misc = REG_WDATA_I & 8'h3b; // Read-only bits are not stored
            `VWCC_IDX_CAP_CTRL: st_next.cap_ctrl = REG_WDATA_I;
            `VWCC_IDX_CAP_FMT: st_next.cap_fmt = REG_WDATA_I;
            `VWCC_IDX_CAP_HRED: st_next.hred = REG_WDATA_I;
            `VWCC_IDX_CAP_VRED: st_next.vred = REG_WDATA_I;
            `VWCC_IDX_LUMA_CTRL: st_next.luma = REG_WDATA_I;
            default: ;
         endcase
      end
      // Window enable only opens on display vsync leading edge
      case (st_reg.win_state)
         VWCC_WIN_OFF: if (st_next.win_ctrl[`VWCC_WIN_ENABLE]) st_next.win_state = VWCC_WIN_ARMED;
         VWCC_WIN_ARMED: begin
            if (!st_next.win_ctrl[`VWCC_WIN_ENABLE]) st_next.win_state = VWCC_WIN_OFF;
            else if (vs_rise) st_next.win_state = VWCC_WIN_ON;
         end
         VWCC_WIN_ON: if (!st_next.win_ctrl[`VWCC_WIN_ENABLE]) st_next.win_state = VWCC_WIN_OFF;
         default: st_next.win_state = VWCC_WIN_OFF;
      endcase
      take = 1'b0;
      if (vref_fall) begin
         st_next.cap_active = st_reg.cap_fmt[`VWCC_FMT_ENABLE];
         st_next.field_cnt = st_reg.field_cnt + 2'd1;
         case ({st_reg.cap_ctrl[`VWCC_CAP_ALT_HI], st_reg.cap_ctrl[`VWCC_CAP_ALT_LO]})
            2'b00: take = 1'b1;
            2'b01: take = !st_reg.field_cnt[0];
            2'b10: take = st_reg.fld_sync[1];
            default: take = st_reg.field_cnt == 2'd0;
         endcase
         take = take && st_reg.cap_fmt[`VWCC_FMT_ENABLE];
         st_next.field_taken = take;
         if (take) begin
            st_next.cur_buf = ~st_reg.cur_buf;
         end
      end
      // Source chosen at edge time; a change of source is not taken as an edge
      src_edge = st_reg.misc[`VWCC_MISC_IRQ_SRC] ? vref_fall : vs_rise;
      if (!st_next.misc[`VWCC_MISC_IRQ_EN]) begin
         st_next.irq_pend = 1'b0;
      end else if (src_edge) begin
         st_next.irq_pend = 1'b1;
      end
      st_next.rdata = read_index(st_next, REG_INDEX_I);
      // Word halves: low half kept at offset/2, high half discarded
      st_next.drop = APERTURE_WRITE_I && decim_on && (APERTURE_BE_I[3:2] != 2'b00);
      st_next.daddr = decim_on ? {st_reg.misc[`VWCC_MISC_PAGE], APERTURE_OFFSET_I[21:1]} : APERTURE_OFFSET_I;
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         st_reg <= '0;
         st_reg.win_state <= VWCC_WIN_OFF;
      end else begin
         st_reg <= st_next;
      end
   end

   assign stride12 = {st_reg.addr_high[`VWCC_STRIDE_EXT_BIT], st_reg.stride, 3'b000};
   assign cap_stride = st_reg.luma[`VWCC_LUMA_FORCE_OFS] ? `VWCC_FORCED_STRIDE :
      (st_reg.cap_ctrl[`VWCC_CAP_INTERLACE] ? {stride12, 1'b0} : {1'b0, stride12});
   assign rgb_disp = (st_reg.win_ctrl[3:1] == VWCC_DISP_RGB555) || (st_reg.win_ctrl[3:1] == VWCC_DISP_RGB565);
   assign decim_on = st_reg.misc[`VWCC_MISC_DECIM] && (st_reg.win_ctrl[3:1] != 3'h0) && rgb_disp;
   assign hred_ok = (st_reg.cap_fmt[2:0] == VWCC_CAP_YUV16) || (st_reg.cap_fmt[2:0] == VWCC_CAP_RGB16);

   assign REG_RDATA_O = st_reg.rdata;
   assign WINDOW_ACTIVE_O = st_reg.win_state == VWCC_WIN_ON;
   assign OVERLAY_EN_O = st_reg.win_ctrl[`VWCC_WIN_OVERLAY];
   assign DITHER_EN_O = st_reg.win_ctrl[`VWCC_WIN_DITHER] && (st_reg.win_ctrl[3:1] == VWCC_DISP_PACKED);
   assign ZOOM_REPLICATE_O = st_reg.win_ctrl[`VWCC_WIN_ZOOM_REPL];
   assign DISPLAY_FORMAT_O = st_reg.win_ctrl[3:1];
   assign DISPLAY_FORMAT_RESERVED_O = (st_reg.win_ctrl[3:1] == 3'h3) || (st_reg.win_ctrl[3:2] == 2'b11);
   assign WINDOW_STRIDE_O = stride12;
   assign CAPTURE_STRIDE_O = cap_stride;
   // Odd fields begin one stride in (the undoubled one) when interlacing
   assign CAPTURE_FIELD_START_O = (st_reg.cap_ctrl[`VWCC_CAP_INTERLACE] && st_reg.fld_sync[1]) ?
      (st_reg.luma[`VWCC_LUMA_FORCE_OFS] ? `VWCC_FORCED_STRIDE : {1'b0, stride12}) : 13'h0000;
   assign CAPTURE_ACTIVE_O = st_reg.cap_active;
   assign CAPTURE_FIELD_TAKEN_O = st_reg.field_taken;
   assign CAPTURE_CLOCK_INVERT_O = st_reg.cap_ctrl[`VWCC_CAP_CLK_INV];
   assign CAPTURE_PORT16_O = st_reg.cap_ctrl[`VWCC_CAP_PORT16];
   assign CAPTURE_DOUBLE_EDGE_O = st_reg.cap_ctrl[`VWCC_CAP_DOUBLE_EDGE];
   assign FEATURE_CONNECTOR_O = st_reg.cap_ctrl[1:0] == 2'b00;
   assign PIXEL_KEEP_O = link_keep;
   assign DECIMATE_DROP_O = st_reg.drop;
   assign DECIMATE_ADDR_O = st_reg.daddr;
   assign INTERRUPT_REQUEST_PIN_N_O = ~st_reg.irq_pend;

   a_win_enable_wait: assert property (@(posedge CLK_I) disable iff (RST_I)
      $rose(WINDOW_ACTIVE_O) |-> $past(vs_rise)) else $error("window opened without vsync");
   a_win_disable_now: assert property (@(posedge CLK_I) disable iff (RST_I)
      (REG_WRITE_I && REG_INDEX_I == `VWCC_IDX_WIN_CTRL && !REG_WDATA_I[0]) |=> !WINDOW_ACTIVE_O)
      else $error("window not closed at once");
   a_irq_clear_wr: assert property (@(posedge CLK_I) disable iff (RST_I)
      (REG_WRITE_I && REG_INDEX_I == `VWCC_IDX_MISC && !REG_WDATA_I[1]) |=> INTERRUPT_REQUEST_PIN_N_O)
      else $error("interrupt not cleared");
   a_irq_on_edge: assert property (@(posedge CLK_I) disable iff (RST_I)
      (src_edge && st_next.misc[1]) |=> !INTERRUPT_REQUEST_PIN_N_O) else $error("interrupt missed");
   a_cap_stride_force: assert property (@(posedge CLK_I) disable iff (RST_I)
      st_reg.luma[7] |-> CAPTURE_STRIDE_O == 13'h0400) else $error("forced stride wrong");
   a_cap_stride_dbl: assert property (@(posedge CLK_I) disable iff (RST_I)
      (!st_reg.luma[7] && st_reg.cap_ctrl[6]) |-> CAPTURE_STRIDE_O == {WINDOW_STRIDE_O, 1'b0})
      else $error("interleave stride not doubled");
   a_cap_enable_edge: assert property (@(posedge CLK_I) disable iff (RST_I)
      !vref_fall |=> $stable(CAPTURE_ACTIVE_O)) else $error("capture enable changed mid field");
   a_buf_toggle: assert property (@(posedge CLK_I) disable iff (RST_I)
      (vref_fall && !st_reg.cap_fmt[3]) |=> $stable(st_reg.cur_buf) && !CAPTURE_FIELD_TAKEN_O)
      else $error("field taken while disabled");
   a_decim_addr: assert property (@(posedge CLK_I) disable iff (RST_I)
      decim_on |=> DECIMATE_ADDR_O[21] == $past(st_reg.misc[0])) else $error("page bit not applied");
endmodule
`default_nettype wire

// file: shared/vwcc_params.svh
// Register indices, field positions, reset values and timing counts of the video window/capture control
`ifndef VWCC_PARAMS_SVH
`define VWCC_PARAMS_SVH
`define VWCC_IDX_WIN_ADDR_HIGH 8'h3c
`define VWCC_IDX_STRIDE 8'h3d
`define VWCC_IDX_WIN_CTRL 8'h3e
`define VWCC_IDX_MISC 8'h3f
`define VWCC_IDX_CAP_CTRL 8'h50
`define VWCC_IDX_CAP_FMT 8'h51
`define VWCC_IDX_CAP_HRED 8'h52
`define VWCC_IDX_CAP_VRED 8'h53
`define VWCC_IDX_LUMA_CTRL 8'h5c
`define VWCC_RESET_VALUE 8'h00
`define VWCC_STRIDE_EXT_BIT 5
`define VWCC_WIN_OVERLAY 7
`define VWCC_WIN_DITHER 5
`define VWCC_WIN_ZOOM_REPL 4
`define VWCC_WIN_ENABLE 0
`define VWCC_MISC_VREF 7
`define VWCC_MISC_FIELD 6
`define VWCC_MISC_IRQ_SRC 5
`define VWCC_MISC_DECIM 4
`define VWCC_MISC_CUR_BUF 2
`define VWCC_MISC_IRQ_EN 1
`define VWCC_MISC_PAGE 0
`define VWCC_CAP_ALT_HI 7
`define VWCC_CAP_INTERLACE 6
`define VWCC_CAP_CLK_INV 5
`define VWCC_CAP_PORT16 4
`define VWCC_CAP_DOUBLE_EDGE 3
`define VWCC_CAP_ALT_LO 2
`define VWCC_FMT_ENABLE 3
`define VWCC_LUMA_FORCE_OFS 7
`define VWCC_FORCED_STRIDE 13'h0400
`define VWCC_SYNC_STAGES 2
`endif

// file: shared/vwcc_pkg.sv
// Types shared by the video window/capture control
`default_nettype none
package vwcc_pkg;
   typedef enum logic [2:0] {
      VWCC_DISP_YUV422 = 3'h0,
      VWCC_DISP_PACKED = 3'h1,
      VWCC_DISP_LUT8 = 3'h2,
      VWCC_DISP_RGB555 = 3'h4,
      VWCC_DISP_RGB565 = 3'h5
   } vwcc_disp_fmt_e;
   typedef enum logic [2:0] {
      VWCC_CAP_YUV16 = 3'h0,
      VWCC_CAP_RGB16 = 3'h1,
      VWCC_CAP_PACKED = 3'h2,
      VWCC_CAP_YUV2PACKED = 3'h3,
      VWCC_CAP_LUMA = 3'h7
   } vwcc_cap_fmt_e;
   typedef enum logic [2:0] {
      VWCC_WIN_OFF = 3'b001,
      VWCC_WIN_ARMED = 3'b010,
      VWCC_WIN_ON = 3'b100
   } vwcc_win_state_e;
endpackage
`default_nettype wire

// file: tb/tb.sv
// Register-level testbench of the video window and capture control
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
   import vwcc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, cap_clk = 1'b0, cap_rst = 1'b1;
   logic [7:0] idx = 8'h00, wdata = 8'h00;
   logic wr_en = 1'b0, vsync = 1'b0, ap_wr = 1'b0;
   logic [21:0] ap_ofs = 22'h00_0000;
   logic [3:0] ap_be = 4'h0;
   logic vref, capture_horizontal_ref, win_act, ovl, dith, zoom, fmt_res, cap_act, taken, cinv, p16, dedge, fconn, keep, drop, irq_n;
   logic [7:0] rdata, v;
   logic [2:0] dfmt;
   logic [11:0] wstride;
   logic [12:0] cstride, fstart;
   logic [21:0] daddr;
   int err_total = 0, tests_run = 0, n = 0;
   initial forever #5 clk = ~clk;
   initial begin
      #17;
      forever #24 cap_clk = ~cap_clk;
   end
   vwcc_video_source vwcc_video_source_inst (.clk_i(cap_clk), .vref_o(vref), .capture_horizontal_ref_o(capture_horizontal_ref));
   vwcc_top vwcc_top_inst (
      .CLK_I(clk), .RST_I(rst), .REG_INDEX_I(idx), .REG_WDATA_I(wdata), .REG_WRITE_I(wr_en),
      .REG_RDATA_O(rdata), .CAP_PIXEL_CLOCK_I(cap_clk), .CAP_RST_I(cap_rst), .CAP_VERTICAL_REF_I(vref),
      .CAPTURE_HORIZONTAL_REF_I(capture_horizontal_ref), .DISP_VSYNC_I(vsync), .APERTURE_WRITE_I(ap_wr),
      .APERTURE_OFFSET_I(ap_ofs), .APERTURE_BE_I(ap_be), .WINDOW_ACTIVE_O(win_act), .OVERLAY_EN_O(ovl),
      .DITHER_EN_O(dith), .ZOOM_REPLICATE_O(zoom), .DISPLAY_FORMAT_O(dfmt), .DISPLAY_FORMAT_RESERVED_O(fmt_res),
      .WINDOW_STRIDE_O(wstride), .CAPTURE_STRIDE_O(cstride), .CAPTURE_FIELD_START_O(fstart),
      .CAPTURE_ACTIVE_O(cap_act), .CAPTURE_FIELD_TAKEN_O(taken), .CAPTURE_CLOCK_INVERT_O(cinv),
      .CAPTURE_PORT16_O(p16), .CAPTURE_DOUBLE_EDGE_O(dedge), .FEATURE_CONNECTOR_O(fconn), .PIXEL_KEEP_O(keep),
      .DECIMATE_DROP_O(drop), .DECIMATE_ADDR_O(daddr), .INTERRUPT_REQUEST_PIN_N_O(irq_n));
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      @(posedge clk);
      idx <= i;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      // Let the registered outputs settle before anyone looks at them
      #1;
   endtask
   task automatic rd(input logic [7:0] i, output logic [7:0] d);
      @(posedge clk);
      idx <= i;
      @(posedge clk);
      #1 d = rdata;
   endtask
   // Runs one field and samples the status mirror while the reference is low
   task automatic run_field();
      fork
         vwcc_video_source_inst.make_field();
         begin
            repeat (20) @(posedge clk);
            rd(8'h3f, v);
            `CHK(v[7], 1'b0)
         end
      join
      repeat (12) @(posedge clk);
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      give_verdict();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge cap_clk);
      cap_rst <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         rd(8'h50 + k[7:0], v);
         `CHK(v, 8'h00)
      end
      `CHK(irq_n, 1'b1)
      wr(8'h00, 8'h5a);
      rd(8'h00, v);
      `CHK(v, 8'h00)
      wr(8'h3f, 8'hc4);
      rd(8'h3f, v);
      `CHK(v, 8'h80)
      // Stride assembly and the capture variants
      wr(8'h3c, 8'h20);
      wr(8'h3d, 8'hab);
      rd(8'h3d, v);
      `CHK(v, 8'hab)
      `CHK(wstride, 12'hd58)
      `CHK(cstride, 13'h0d58)
      wr(8'h50, 8'h40);
      `CHK(cstride, 13'h1ab0)
      // Display format decode for every code
      for (int f = 0; f < 8; f++) begin
         wr(8'h3e, {4'h0, f[2:0], 1'b0});
         `CHK(dfmt, f[2:0])
         `CHK(fmt_res, (f == 3 || f >= 6))
      end
      wr(8'h3e, 8'hb3);
      `CHK({ovl, dith, zoom}, 3'b111)
      wr(8'h3e, 8'h23);
      `CHK({ovl, dith, zoom}, 3'b010)
      wr(8'h3e, 8'h03);
      `CHK(dith, 1'b0)
      repeat (6) @(posedge clk);
      #1 `CHK(win_act, 1'b0)
      vsync <= 1'b1;
      repeat (8) @(posedge clk);
      vsync <= 1'b0;
      #1 `CHK(win_act, 1'b1)
      wr(8'h3e, 8'h02);
      @(posedge clk);
      #1 `CHK(win_act, 1'b0)
      // Capture port options and pin configurations
      for (int p = 0; p < 4; p++) begin
         wr(8'h50, 8'h38 | p[7:0]);
         `CHK({cinv, p16, dedge, fconn}, {3'b111, p == 0})
      end
      wr(8'h50, 8'h02);
      `CHK({cinv, p16, dedge, fconn}, 4'b0000)
      // Capture start waits for a reference fall, then interrupt and field tracking
      wr(8'h50, 8'h42);
      wr(8'h52, 8'h00);
      wr(8'h51, 8'h08);
      wr(8'h3f, 8'h22);
      repeat (10) @(posedge clk);
      #1 `CHK({cap_act, fstart}, {1'b0, 13'h0000})
      run_field();
      #1 `CHK({cap_act, taken, irq_n}, 3'b110)
      `CHK(fstart, 13'h0d58)
      rd(8'h3f, v);
      `CHK(v, 8'he6)
      wr(8'h3f, 8'h20);
      @(posedge clk);
      #1 `CHK(irq_n, 1'b1)
      run_field();
      #1 `CHK({irq_n, fstart}, {1'b1, 13'h0000})
      wr(8'h5c, 8'h80);
      `CHK(cstride, 13'h0400)
      `CHK(wstride, 12'hd58)
      wr(8'h3f, 8'h02);
      run_field();
      #1 `CHK(irq_n, 1'b1)
      // Display vsync is the source now, so its rising edge must raise the request
      vsync <= 1'b1;
      repeat (6) @(posedge clk);
      vsync <= 1'b0;
      #1 `CHK(irq_n, 1'b0)
      wr(8'h51, 8'h00);
      run_field();
      #1 `CHK({cap_act, taken}, 2'b00)
      // Keep every 32nd pixel: a free-running line gives one kept pixel per 32 link clocks
      wr(8'h52, 8'h05);
      repeat (4) @(negedge cap_clk);
      n = 0;
      repeat (32) begin
         @(negedge cap_clk);
         n += int'(keep);
      end
      `CHK(n, 1)
      // Auto-decimation on an RGB display format with the upper page selected
      wr(8'h3e, 8'h08);
      wr(8'h3f, 8'h11);
      @(posedge clk);
      ap_wr <= 1'b1;
      ap_ofs <= 22'h00_0100;
      ap_be <= 4'hc;
      @(posedge clk);
      ap_ofs <= 22'h00_0200;
      ap_be <= 4'h3;
      #1 `CHK(drop, 1'b1)
      `CHK(daddr, 22'h20_0080)
      @(posedge clk);
      ap_wr <= 1'b0;
      #1 `CHK(drop, 1'b0)
      `CHK(daddr, 22'h20_0100)
      give_verdict();
   end
endmodule
`default_nettype wire

// file: tb/vwcc_video_source.sv
// Behavioural video source that drives the capture reference strobes
`default_nettype none
module vwcc_video_source (
   input wire logic clk_i,
   output logic vref_o,
   output logic capture_horizontal_ref_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Vertical reference idles high between fields, so each field starts on a falling edge
   initial begin
      vref_o = 1'b1;
      capture_horizontal_ref_o = 1'b0;
   end
   task automatic make_field();
      @(posedge clk_i);
      vref_o <= 1'b0;
      repeat (4) begin
         repeat (2) @(posedge clk_i);
         capture_horizontal_ref_o <= 1'b1;
         repeat (8) @(posedge clk_i);
         capture_horizontal_ref_o <= 1'b0;
      end
      repeat (2) @(posedge clk_i);
      vref_o <= 1'b1;
   endtask
endmodule
`default_nettype wire
